// >>> bench/spc_motor_model.sv
module spc_motor_model import spc_pkg::*; (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [15:0] load_current, // Phase current drawn by the load
    input wire logic [15:0] speed,        // Shaft frequency, 0.01 Hz
    input wire spc_phase_t phase,         // Ramp phase of the drive
    output spc_meas_t meas
);
    timeunit 1ns;
    timeprecision 100ps;
    ////////////////////////////////////////////////////////////////////////
    // Sensing lags the load by one cycle; torque share is half the current
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meas <= '0;
        end else begin
            meas.out_current <= load_current;
            meas.torque_current <= {1'b0, load_current[15:1]};
            meas.out_freq <= speed;
            meas.phase <= phase;
        end
    end
endmodule

// >>> bench/tb.sv
module tb import spc_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, sss = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [1:0] htrans = 0;
    logic hreadyout, hresp, shut, warn, ovs, stop, irq;
    logic [15:0] cur = 0, spd = 0; // Load current and speed
    spc_phase_t ph = SPC_PH_STOP;
    spc_meas_t meas;
    spc_action_t fa;
    int mismatches = 0, total_checks = 0;
    always #2.5 hclk = ~hclk;
    // Short warning step keeps the delay test quick
    spc_stall_ctrl #(.STEP_CYCLES(4)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .meas(meas), .second_set_select(sss), .freq_action(fa), .output_shutoff(shut),
        .overload_warning_out(warn), .ov_suppress(ovs), .stop_request(stop), .irq(irq));
    spc_motor_model motor (.hclk(hclk), .hresetn(hresetn), .load_current(cur),
        .speed(spd), .phase(ph), .meas(meas));
    ////////////////////////////////////////////////////////////////////////
    // Compare and count
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("BAD %0t got %h expected %h", $time, got, exp);
            mismatches++;
        end
    endtask
    // One AHB single transfer; waits on hready, never on a fixed count
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1; haddr <= {24'h000000, a}; htrans <= 2'h2; hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0; hsel <= 1'b0; hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
        chk(hresp, 1'b0); // Slave always answers OKAY
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0); chk(rd, e);
    endtask
    // Apply a load, let it settle, judge the frequency action
    task act(input logic [15:0] c, input spc_phase_t p, input spc_action_t e);
        cur <= c; ph <= p; repeat (5) @(posedge hclk); chk(32'(fa), 32'(e));
    endtask
    ////////////////////////////////////////////////////////////////////////
    task s_reset();
        rdc(SPC_OFS_LEVEL1, 32'h05DC);
        rdc(SPC_OFS_SELECT, 32'h0);
        rdc(SPC_OFS_LEVEL2, 32'h270F);
        rdc(SPC_OFS_DBL_FACTOR, 32'h270F);
        rdc(SPC_OFS_RED_FREQ, 32'h1770);
        rdc(SPC_OFS_OV_SEL, 32'h1);
        rdc(SPC_OFS_OL_DELAY, 32'h0);
        rdc(8'h3C, 32'h0); // Unmapped reads zero
    endtask
    task s_phases();
        wr(SPC_OFS_INT_MASK, 32'h1);
        act(16'h0640, SPC_PH_ACCEL, SPC_FA_DECEL);
        chk(warn, 1'b1);
        chk(irq, 1'b1);
        act(16'h0640, SPC_PH_CONST, SPC_FA_DECEL);
        act(16'h0640, SPC_PH_DECEL, SPC_FA_HOLD);
        act(16'h0640, SPC_PH_STOP, SPC_FA_NONE);
        act(16'h03E8, SPC_PH_ACCEL, SPC_FA_NONE);
        chk(warn, 1'b0);
        wr(SPC_OFS_INT_STAT, 32'h7);
        repeat (3) @(posedge hclk);
        chk(irq, 1'b0);
    endtask
    task s_clamp();
        wr(SPC_OFS_LEVEL1, 32'h0BB8);
        act(16'h0640, SPC_PH_ACCEL, SPC_FA_DECEL);
        act(16'h05AA, SPC_PH_ACCEL, SPC_FA_NONE);
        wr(SPC_OFS_CTRL, 32'h1);
        act(16'h076C, SPC_PH_ACCEL, SPC_FA_NONE);
        act(16'h0834, SPC_PH_ACCEL, SPC_FA_DECEL);
        wr(SPC_OFS_CTRL, 32'h0); wr(SPC_OFS_LEVEL1, 32'h05DC);
    endtask
    task s_select();
        act(16'h0708, SPC_PH_CONST, SPC_FA_DECEL);
        chk(shut, 1'b1);
        wr(SPC_OFS_SELECT, 32'h1);
        act(16'h0708, SPC_PH_CONST, SPC_FA_DECEL);
        chk(shut, 1'b0);
        wr(SPC_OFS_SELECT, 32'h32);
        rdc(SPC_OFS_SELECT, 32'h1);
        wr(SPC_OFS_SELECT, 32'h2);
        act(16'h0640, SPC_PH_ACCEL, SPC_FA_NONE);
        wr(SPC_OFS_SELECT, 32'h10);
        act(16'h0640, SPC_PH_ACCEL, SPC_FA_DECEL);
        chk(stop, 1'b1);
        wr(SPC_OFS_SELECT, 32'h65);
        act(16'h0708, SPC_PH_DECEL, SPC_FA_HOLD);
        chk(shut, 1'b0);
        chk(stop, 1'b0);
        wr(SPC_OFS_SELECT, 32'h0);
    endtask
    task s_ov_delay();
        wr(SPC_OFS_OV_SEL, 32'hB);
        act(16'h0640, SPC_PH_ACCEL, SPC_FA_DECEL);
        chk(ovs, 1'b1);
        act(16'h0, SPC_PH_ACCEL, SPC_FA_NONE);
        wr(SPC_OFS_OL_DELAY, 32'h2);
        act(16'h0640, SPC_PH_ACCEL, SPC_FA_DECEL);
        chk(warn, 1'b0);
        repeat (10) @(posedge hclk); chk(warn, 1'b1);
        act(16'h0, SPC_PH_ACCEL, SPC_FA_NONE);
        wr(SPC_OFS_OL_DELAY, 32'h270F);
        act(16'h0640, SPC_PH_ACCEL, SPC_FA_DECEL);
        repeat (20) @(posedge hclk); chk(warn, 1'b0);
        wr(SPC_OFS_OL_DELAY, 32'h0); wr(SPC_OFS_OV_SEL, 32'h1);
    endtask
    task s_modes();
        // Pin passes a three-stage synchroniser: give it time before judging
        sss <= 1'b1;
        wr(SPC_OFS_LEVEL2, 32'h03E8);
        act(16'h04B0, SPC_PH_ACCEL, SPC_FA_DECEL);
        wr(SPC_OFS_SEC_FMAX, 32'h0064);
        spd <= 16'h0FA0;
        act(16'h04B0, SPC_PH_ACCEL, SPC_FA_NONE);
        wr(SPC_OFS_SEC_FMAX, 32'h0);
        spd <= 16'h0;
        sss <= 1'b0;
        repeat (2) @(posedge hclk);
        act(16'h04B0, SPC_PH_ACCEL, SPC_FA_NONE);
        wr(SPC_OFS_CMP_SEL, 32'h1);
        act(16'h0640, SPC_PH_ACCEL, SPC_FA_NONE);
        wr(SPC_OFS_CMP_SEL, 32'h0); spd <= 16'h32C8;
        act(16'h0640, SPC_PH_CONST, SPC_FA_NONE);
        wr(SPC_OFS_DBL_FACTOR, 32'h0032);
        act(16'h03E8, SPC_PH_CONST, SPC_FA_DECEL);
        wr(SPC_OFS_DBL_FACTOR, 32'h270F);
        spd <= 16'h0; wr(SPC_OFS_CTRL, 32'h4);
        act(16'h0640, SPC_PH_CONST, SPC_FA_NONE);
        wr(SPC_OFS_CTRL, 32'h0); wr(SPC_OFS_LEVEL1, 32'h0);
        act(16'h0640, SPC_PH_CONST, SPC_FA_NONE);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task test_done();
        if (mismatches == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Watchdog: the sequence needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge hclk);
        mismatches++;
        test_done();
    end
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        s_reset(); s_phases(); s_clamp(); s_select(); s_ov_delay(); s_modes();
        test_done();
    end
endmodule

// >>> design/spc_pkg.sv
package spc_pkg;

    // Register byte offsets, one aligned word each
    localparam logic [7:0] SPC_OFS_LEVEL1 = 8'h00;
    localparam logic [7:0] SPC_OFS_SELECT = 8'h04;
    localparam logic [7:0] SPC_OFS_LEVEL2 = 8'h08;
    localparam logic [7:0] SPC_OFS_DBL_FACTOR = 8'h0C;
    localparam logic [7:0] SPC_OFS_RED_FREQ = 8'h10;
    localparam logic [7:0] SPC_OFS_OV_SEL = 8'h14;
    localparam logic [7:0] SPC_OFS_OL_DELAY = 8'h18;
    localparam logic [7:0] SPC_OFS_CMP_SEL = 8'h1C;
    localparam logic [7:0] SPC_OFS_CTRL = 8'h20;
    localparam logic [7:0] SPC_OFS_FAST_LIMIT = 8'h24;
    localparam logic [7:0] SPC_OFS_SEC_FMAX = 8'h28;
    localparam logic [7:0] SPC_OFS_STATUS = 8'h2C;
    localparam logic [7:0] SPC_OFS_INT_STAT = 8'h30;
    localparam logic [7:0] SPC_OFS_INT_MASK = 8'h34;

    // Levels in 0.1 % of rated current, frequencies in 0.01 Hz
    localparam logic [15:0] SPC_CODE_OFF = 16'h270F;
    localparam logic [15:0] SPC_LEVEL_MAX = 16'h0FA0;
    localparam logic [15:0] SPC_CLAMP_LD = 16'h05DC;
    localparam logic [15:0] SPC_CLAMP_ND = 16'h07D0;
    localparam logic [15:0] SPC_FACTOR_MAX = 16'h00C8;
    localparam logic [15:0] SPC_FREQ_MAX = 16'hE678;
    localparam logic [15:0] SPC_DELAY_MAX = 16'h00FA;
    localparam logic [15:0] SPC_SEL_MAX = 16'h001F;
    localparam logic [15:0] SPC_SEL_ALT0 = 16'h0064;
    localparam logic [15:0] SPC_SEL_ALT1 = 16'h0065;
    localparam logic [15:0] SPC_OV_PASS = 16'h0001;
    localparam logic [15:0] SPC_OV_SUPPRESS = 16'h000B;

    // Values after reset
    localparam logic [15:0] SPC_RST_LEVEL1 = 16'h05DC;
    localparam logic [15:0] SPC_RST_SELECT = 16'h0000;
    localparam logic [15:0] SPC_RST_LEVEL2 = 16'h270F;
    localparam logic [15:0] SPC_RST_FACTOR = 16'h270F;
    localparam logic [15:0] SPC_RST_RED_GR1 = 16'h1770;
    localparam logic [15:0] SPC_RST_RED_GR2 = 16'h1388;
    localparam logic [15:0] SPC_RST_OV_SEL = 16'h0001;
    localparam logic [15:0] SPC_RST_DELAY = 16'h0000;
    localparam logic [15:0] SPC_RST_FAST = 16'h06A4;
    localparam logic [15:0] SPC_RST_SEC_FMAX = 16'h0000;

    // Warning delay step is 0.1 s; cycles at 5 ns
    localparam int SPC_DELAY_STEP_MS = 100;
    localparam int SPC_CLK_PERIOD_NS = 5;
    localparam int SPC_STEP_CYCLES = SPC_DELAY_STEP_MS * 1000000 / SPC_CLK_PERIOD_NS;

    // Drive phase reported by the speed ramp
    typedef enum logic [1:0] {SPC_PH_STOP, SPC_PH_ACCEL, SPC_PH_CONST, SPC_PH_DECEL} spc_phase_t;

    // Frequency action asked of the speed ramp
    typedef enum logic [1:0] {SPC_FA_NONE, SPC_FA_HOLD, SPC_FA_DECEL} spc_action_t;

    // Measurements sampled every control cycle
    typedef struct packed {
        logic [15:0] out_current;
        logic [15:0] torque_current;
        logic [15:0] out_freq;
        spc_phase_t phase;
    } spc_meas_t;

    // Control word: bit0 normal duty, bits 2:1 control method (0 = V/F)
    typedef struct packed {
        logic [12:0] unused;
        logic [1:0] ctrl_method;
        logic normal_duty_rating;
    } spc_ctrl_t;

endpackage

// >>> design/spc_stall_ctrl.sv
// Operation
// - Compare current to level, lower frequency when exceeded
// - Primary level 0.1-400%, reset 150%, zero disables
// - Clamp level to 150% light, 200% normal duty
// - Accel/const decelerate, decel holds frequency
// - Overload warning asserted while stall prevention operates
// - Warning after 0-25 s delay, 9999 suppresses
// - Second level replaces primary on select input
// - Above rated frequency reduce level by factor
// - Reduction starts at programmable 0-590 Hz frequency
// - Setting 11 suppresses overvoltage protection during stall
// - Compare select picks output or torque current
// - Function select accepts 0-31, 100, 101
// - Fast limit exceeded shuts output off
// - Vector control methods keep function inactive
// - Second function restricts active frequency range
// - Select bits disable fast limit and phases; bit 4 enables warning-stop
//
// The AHB-Lite register port and the register addresses were chosen for this implementation.
module spc_stall_ctrl import spc_pkg::*; #(
    parameter int STEP_CYCLES = SPC_STEP_CYCLES,
    parameter bit INIT_GROUP2 = 1'b0
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire spc_meas_t meas,
    input wire logic second_set_select,
    output spc_action_t freq_action,
    output logic output_shutoff,
    output logic overload_warning_out,
    output logic ov_suppress,
    output logic stop_request,
    output logic irq
);

    if (STEP_CYCLES < 1 || STEP_CYCLES > 33554432) begin // Step counter is 25 bits
        $error("STEP_CYCLES must lie between one and the step counter range");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave

    logic [15:0] level1_r, select_r, level2_r, factor_r, red_freq_r;
    logic [15:0] ov_sel_r, delay_r, fast_r, sec_fmax_r;
    logic cmp_sel_r;
    spc_ctrl_t ctrl_r;
    logic [2:0] int_stat_r, int_mask_r;
    logic wr_pend_r; // Write data phase pending
    logic [7:0] wr_addr_r; // Latched write offset
    logic [31:0] rd_word; // Read mux
    logic [15:0] wd; // Write data, low half
    logic addr_ok;
    logic [2:0] ev; // Events: stall start, fast trip, warning start

    assign wd = hwdata[15:0];
    assign addr_ok = hsel && hready && htrans[1];

    // Zero wait, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Latch write address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end else begin
            wr_pend_r <= addr_ok && hwrite;
            if (addr_ok && hwrite) wr_addr_r <= haddr[7:0];
        end
    end

    // Writes land at end of data phase; out-of-range codes are ignored, but compare select, control and mask writes keep only their low bits
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            level1_r <= SPC_RST_LEVEL1;
            select_r <= SPC_RST_SELECT;
            level2_r <= SPC_RST_LEVEL2;
            factor_r <= SPC_RST_FACTOR;
            red_freq_r <= INIT_GROUP2 ? SPC_RST_RED_GR2 : SPC_RST_RED_GR1;
            ov_sel_r <= SPC_RST_OV_SEL;
            delay_r <= SPC_RST_DELAY;
            cmp_sel_r <= 1'b0;
            ctrl_r <= '0;
            fast_r <= SPC_RST_FAST;
            sec_fmax_r <= SPC_RST_SEC_FMAX;
            int_mask_r <= 3'h0;
        end else if (wr_pend_r) begin
            unique case (wr_addr_r)
                SPC_OFS_LEVEL1: if (wd <= SPC_LEVEL_MAX) level1_r <= wd;
                SPC_OFS_SELECT: begin
                    if (wd <= SPC_SEL_MAX || wd == SPC_SEL_ALT0 || wd == SPC_SEL_ALT1)
                        select_r <= wd;
                end
                SPC_OFS_LEVEL2: begin
                    if (wd <= SPC_LEVEL_MAX || wd == SPC_CODE_OFF) level2_r <= wd;
                end
                SPC_OFS_DBL_FACTOR: begin
                    if (wd <= SPC_FACTOR_MAX || wd == SPC_CODE_OFF) factor_r <= wd;
                end
                SPC_OFS_RED_FREQ: if (wd <= SPC_FREQ_MAX) red_freq_r <= wd;
                SPC_OFS_OV_SEL: begin
                    if (wd == SPC_OV_PASS || wd == SPC_OV_SUPPRESS) ov_sel_r <= wd;
                end
                SPC_OFS_OL_DELAY: begin
                    if (wd <= SPC_DELAY_MAX || wd == SPC_CODE_OFF) delay_r <= wd;
                end
                SPC_OFS_CMP_SEL: cmp_sel_r <= hwdata[0];
                SPC_OFS_CTRL: ctrl_r <= {13'h0000, wd[2:0]};
                SPC_OFS_FAST_LIMIT: if (wd <= SPC_LEVEL_MAX) fast_r <= wd;
                SPC_OFS_SEC_FMAX: if (wd <= SPC_FREQ_MAX) sec_fmax_r <= wd;
                SPC_OFS_INT_MASK: int_mask_r <= hwdata[2:0];
                default: ;
            endcase
        end
    end

    // Sticky events; a new event wins over a write-one clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            int_stat_r <= 3'h0;
        end else if (wr_pend_r && wr_addr_r == SPC_OFS_INT_STAT) begin
            int_stat_r <= (int_stat_r & ~hwdata[2:0]) | ev;
        end else begin
            int_stat_r <= int_stat_r | ev;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser for the second-set select

    logic [2:0] sss_sync_r; // Three-stage chain
    logic sss_r; // Accepted level

    // Only stages two and three are compared
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sss_sync_r <= 3'h0;
            sss_r <= 1'b0;
        end else begin
            sss_sync_r <= {sss_sync_r[1:0], second_set_select};
            if (sss_sync_r[1] == sss_sync_r[2]) sss_r <= sss_sync_r[2];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Level selection and comparison

    logic [15:0] lvl_pick, lvl_eff, cur;
    logic lvl_off, method_ok, phase_ok, over, fast_over;
    logic [25:0] cur_x, lvl_x;
    logic sec_act;

    // Second set only acts within its frequency window
    assign sec_act = sss_r && (sec_fmax_r == 16'h0000 || meas.out_freq <= sec_fmax_r);

    // Pick level; zero in the chosen set disables the comparison
    always_comb begin
        lvl_pick = level1_r;
        if (sec_act && level2_r != SPC_CODE_OFF) lvl_pick = level2_r;
        lvl_off = (level1_r == 16'h0000) || (lvl_pick == 16'h0000);
    end

    // Duty-rating clamp applied after selection
    always_comb begin
        lvl_eff = lvl_pick;
        if (!ctrl_r.normal_duty_rating && lvl_pick > SPC_CLAMP_LD) lvl_eff = SPC_CLAMP_LD;
        if (ctrl_r.normal_duty_rating && lvl_pick > SPC_CLAMP_ND) lvl_eff = SPC_CLAMP_ND;
    end

    assign cur = cmp_sel_r ? meas.torque_current : meas.out_current;

    // Reduction avoids a divider: cross-multiplied at 1x, mid band, 2x start
    always_comb begin
        cur_x = 26'({10'h000, cur} * 26'd100);
        lvl_x = 26'({10'h000, lvl_eff} * 26'd100);
        if (factor_r != SPC_CODE_OFF && meas.out_freq > red_freq_r) begin
            if ({1'b0, meas.out_freq} >= {red_freq_r, 1'b0}) begin
                lvl_x = 26'({10'h000, lvl_eff} * {10'h000, factor_r});
            end else begin
                cur_x = 26'({10'h000, cur} * 26'd200);
                lvl_x = 26'({10'h000, lvl_eff} * 26'({10'h000, factor_r} + 26'd100));
            end
        end
        over = (cur_x > lvl_x) && !lvl_off;
        // Factor code 9999 disables the function from twice the start frequency
        if (factor_r == SPC_CODE_OFF && {1'b0, meas.out_freq} >= {red_freq_r, 1'b0})
            over = 1'b0;
    end

    assign method_ok = (ctrl_r.ctrl_method == 2'b00);
    assign fast_over = method_ok && !select_r[0] && (meas.out_current > fast_r);

    // Phase masks; codes 100 and 101 keep accel, const and decel enabled
    always_comb begin
        phase_ok = 1'b0;
        unique case (meas.phase)
            SPC_PH_ACCEL: phase_ok = (select_r > SPC_SEL_MAX) || !select_r[1];
            SPC_PH_CONST: phase_ok = (select_r > SPC_SEL_MAX) || !select_r[2];
            SPC_PH_DECEL: phase_ok = (select_r > SPC_SEL_MAX) || !select_r[3];
            SPC_PH_STOP: phase_ok = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Stall action and warning timing

    logic stall_r; // Stall prevention operating
    logic [24:0] step_cnt_r; // Cycles within one delay step
    logic [15:0] steps_r; // Elapsed delay steps
    logic warn_nxt;

    // Registered comparison each control cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stall_r <= 1'b0;
        end else begin
            stall_r <= over && phase_ok && method_ok;
        end
    end

    // Ramp command per phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            freq_action <= SPC_FA_NONE;
        end else if (!(over && phase_ok && method_ok)) begin
            freq_action <= SPC_FA_NONE;
        end else if (meas.phase == SPC_PH_DECEL) begin
            freq_action <= SPC_FA_HOLD;
        end else begin
            freq_action <= SPC_FA_DECEL;
        end
    end

    // Delay counter restarts each time stall prevention starts
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            step_cnt_r <= '0;
            steps_r <= 16'h0000;
        end else if (!stall_r) begin
            step_cnt_r <= '0;
            steps_r <= 16'h0000;
        end else if (step_cnt_r == 25'(STEP_CYCLES - 1)) begin
            step_cnt_r <= '0;
            if (steps_r != 16'hFFFF) steps_r <= steps_r + 16'h0001;
        end else begin
            step_cnt_r <= step_cnt_r + 25'd1;
        end
    end

    assign warn_nxt = stall_r && delay_r != SPC_CODE_OFF && steps_r >= delay_r;

    // Outputs straight from flops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            overload_warning_out <= 1'b0;
            output_shutoff <= 1'b0;
            ov_suppress <= 1'b0;
            stop_request <= 1'b0;
            irq <= 1'b0;
        end else begin
            overload_warning_out <= warn_nxt;
            output_shutoff <= fast_over;
            ov_suppress <= stall_r && ov_sel_r == SPC_OV_SUPPRESS;
            // Stop on warning only for the 16-weight codes
            stop_request <= warn_nxt && select_r <= SPC_SEL_MAX && select_r[4];
            irq <= |(int_stat_r & int_mask_r);
        end
    end

    // Event edges for status
    assign ev = {warn_nxt && !overload_warning_out, fast_over && !output_shutoff,
                 over && phase_ok && method_ok && !stall_r};

    ////////////////////////////////////////////////////////////////////////////
    // Read path; a register still in its write data phase reads zero

    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (haddr[7:0])
            SPC_OFS_LEVEL1: rd_word = {16'h0000, level1_r};
            SPC_OFS_SELECT: rd_word = {16'h0000, select_r};
            SPC_OFS_LEVEL2: rd_word = {16'h0000, level2_r};
            SPC_OFS_DBL_FACTOR: rd_word = {16'h0000, factor_r};
            SPC_OFS_RED_FREQ: rd_word = {16'h0000, red_freq_r};
            SPC_OFS_OV_SEL: rd_word = {16'h0000, ov_sel_r};
            SPC_OFS_OL_DELAY: rd_word = {16'h0000, delay_r};
            SPC_OFS_CMP_SEL: rd_word = {31'h0, cmp_sel_r};
            SPC_OFS_CTRL: rd_word = {16'h0000, ctrl_r};
            SPC_OFS_FAST_LIMIT: rd_word = {16'h0000, fast_r};
            SPC_OFS_SEC_FMAX: rd_word = {16'h0000, sec_fmax_r};
            SPC_OFS_STATUS: rd_word = {26'h0, sss_r, ov_suppress, stop_request,
                                       output_shutoff, overload_warning_out, stall_r};
            SPC_OFS_INT_STAT: rd_word = {29'h0, int_stat_r};
            SPC_OFS_INT_MASK: rd_word = {29'h0, int_mask_r};
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // Captured at the address phase; a back-to-back read of a just-written
    // register would otherwise see the old value, so refuse it to the bus
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            hrdata <= (wr_pend_r && wr_addr_r == haddr[7:0]) ? 32'h0000_0000 : rd_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    a_level_clamp_ld: assert property (@(posedge hclk) disable iff (!hresetn)
        !ctrl_r.normal_duty_rating |-> lvl_eff <= SPC_CLAMP_LD)
        else $error("level above light duty clamp");
    a_level_clamp_nd: assert property (@(posedge hclk) disable iff (!hresetn)
        lvl_eff <= SPC_CLAMP_ND)
        else $error("level above normal duty clamp");
    a_zero_level_off: assert property (@(posedge hclk) disable iff (!hresetn)
        level1_r == 16'h0000 |=> !stall_r)
        else $error("stall with zero level");
    a_vector_inact: assert property (@(posedge hclk) disable iff (!hresetn)
        ctrl_r.ctrl_method != 2'b00 |=> !stall_r && !output_shutoff)
        else $error("active under vector control");
    a_decel_holds: assert property (@(posedge hclk) disable iff (!hresetn)
        over && phase_ok && method_ok && meas.phase == SPC_PH_DECEL |=> freq_action == SPC_FA_HOLD)
        else $error("decel phase not held");
    a_accel_decel: assert property (@(posedge hclk) disable iff (!hresetn)
        over && phase_ok && method_ok && meas.phase != SPC_PH_DECEL |=> freq_action == SPC_FA_DECEL)
        else $error("no decel on stall");
    a_warn_needs_stall: assert property (@(posedge hclk) disable iff (!hresetn)
        overload_warning_out |-> $past(stall_r))
        else $error("warning without stall");
    a_warn_zero_delay: assert property (@(posedge hclk) disable iff (!hresetn)
        delay_r == 16'h0000 && stall_r |=> overload_warning_out)
        else $error("zero delay warning late");
    a_warn_suppress: assert property (@(posedge hclk) disable iff (!hresetn)
        delay_r == SPC_CODE_OFF |=> !overload_warning_out)
        else $error("suppressed warning shown");
    a_fast_shutoff: assert property (@(posedge hclk) disable iff (!hresetn)
        select_r[0] && $stable(select_r) |=> !output_shutoff)
        else $error("shutoff while fast limit disabled");
    a_ov_suppress: assert property (@(posedge hclk) disable iff (!hresetn)
        ov_suppress |-> $past(stall_r) && $past(ov_sel_r) == SPC_OV_SUPPRESS)
        else $error("ov suppress without cause");

    c_stall_decel: cover property (@(posedge hclk) disable iff (!hresetn)
        freq_action == SPC_FA_DECEL);
    c_warn_delayed: cover property (@(posedge hclk) disable iff (!hresetn)
        overload_warning_out && delay_r != 16'h0000);
    c_fast_trip: cover property (@(posedge hclk) disable iff (!hresetn) output_shutoff);
    c_second_set: cover property (@(posedge hclk) disable iff (!hresetn) stall_r && sec_act);

endmodule
